/* verilog/sfw_pkg.sv */
package sfw_pkg;
  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int MAX_WORDS = 64;
  localparam int ADDR_W = 6;
  localparam int CNT_W = 7;
  localparam int PAD_W = 2;
  localparam int GPS_DATA_W = 24;
  localparam int GPS_PAR_W = 6;
  localparam int BDS_WORD_W = 30;
  localparam int GAL_PTYPE_BIT = 30;
  localparam logic [CNT_W-1:0] GAL_HALF2_IDX = 7'h04;

  // ----------------------------------------
  // constellation and signal codes
  // ----------------------------------------
  localparam logic [7:0] GNSS_GPS = 8'h00;
  localparam logic [7:0] GNSS_SBAS = 8'h01;
  localparam logic [7:0] GNSS_GAL = 8'h02;
  localparam logic [7:0] GNSS_BDS = 8'h03;
  localparam logic [7:0] GNSS_QZSS = 8'h05;
  localparam logic [7:0] GNSS_GLO = 8'h06;
  localparam logic [7:0] GNSS_NAVIC = 8'h07;
  localparam logic [7:0] SIG_L1CA = 8'h00;
  localparam logic [7:0] SIG_GAL_E1B = 8'h01;
  localparam logic [7:0] SIG_GAL_E5A = 8'h03;
  localparam logic [7:0] SIG_GAL_E5B = 8'h05;
  localparam logic [7:0] SIG_BDS_B2I_D2 = 8'h03;
  localparam logic [7:0] SV_UNKNOWN = 8'hFF;

  // ----------------------------------------
  // word counts per signal
  // ----------------------------------------
  localparam logic [CNT_W-1:0] WC_TEN = 7'h0A;
  localparam logic [CNT_W-1:0] WC_GAL = 7'h08;
  localparam logic [CNT_W-1:0] WC_NINE = 7'h09;
  localparam logic [CNT_W-1:0] WC_B1C = 7'h39;
  localparam logic [CNT_W-1:0] WC_GLO = 7'h03;
  localparam logic [CNT_W-1:0] WC_NONE = 7'h00;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_COLLECT = 3'b001,
    ST_CHECK = 3'b010,
    ST_HDR = 3'b011,
    ST_LOAD = 3'b100,
    ST_SEND = 3'b101,
    ST_TRAIL = 3'b110
  } sfw_state_t;

  // expected payload words; zero for an unsupported signal
  function automatic logic [CNT_W-1:0] sfw_word_count(
    input logic [7:0] gnss, input logic [7:0] sig);
    logic [CNT_W-1:0] wc;
    wc = WC_NONE;
    unique case (gnss)
      GNSS_GPS: if (sig == 8'h00 || sig == 8'h03 || sig == 8'h04 ||
                    sig == 8'h06) wc = WC_TEN;
      GNSS_QZSS: if (sig == 8'h00 || sig == 8'h04 || sig == 8'h05 ||
                     sig == 8'h08) wc = WC_TEN;
      GNSS_SBAS: if (sig == SIG_L1CA) wc = WC_NINE;
      GNSS_GAL: if (sig == SIG_GAL_E1B || sig == SIG_GAL_E5A ||
                    sig == SIG_GAL_E5B) wc = WC_GAL;
      GNSS_BDS: begin
        if (sig <= SIG_BDS_B2I_D2) wc = WC_TEN;
        else if (sig == 8'h05) wc = WC_B1C;
        else if (sig == 8'h07) wc = WC_NINE;
      end
      GNSS_GLO: if (sig == 8'h00 || sig == 8'h02) wc = WC_GLO;
      GNSS_NAVIC: if (sig == 8'h00) wc = WC_TEN;
      default: wc = WC_NONE;
    endcase
    return wc;
  endfunction
endpackage

/* verilog/sfw_mem_if.sv */
`timescale 1ns/10ps
interface sfw_mem_if #(parameter int AW = 6, parameter int DW = 32);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl(output we, output waddr, output wdata, output raddr,
              input rdata);
  modport mem(input we, input waddr, input wdata, input raddr,
              output rdata);
endinterface

/* verilog/sfw_mem.sv */
`timescale 1ns/10ps
module sfw_mem #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  input wire clk,
  sfw_mem_if.mem port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rd_reg;

  // refused at elaboration: address must select at least four words
  if (AW < 2 || DW < 1) begin : g_bad_size
    $error("sfw_mem: bad size");
  end

  // read data registered: one cycle from address to data
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    rd_reg <= store[port.raddr];
  end
  assign port.rdata = rd_reg;
endmodule

/* verilog/sfw_fmt.sv */
`timescale 1ns/10ps
module sfw_fmt
  import sfw_pkg::*;
(
  input wire logic [7:0] gnss,
  input wire logic [7:0] sig,
  input wire logic [CNT_W-1:0] idx,
  input wire logic alert,
  input wire logic prev_d30,
  input wire logic [DATA_W-1:0] raw,
  output logic [DATA_W-1:0] word,
  output logic d30
);
  logic l1ca;
  assign l1ca = (gnss == GNSS_GPS || gnss == GNSS_QZSS) && sig == SIG_L1CA;

  always_comb begin
    word = raw;
    d30 = raw[0];
    if (l1ca) begin
      // data bits undone here so the host needs no parity logic
      word = {{PAD_W{1'b0}},
              raw[GPS_DATA_W+GPS_PAR_W-1:GPS_PAR_W] ^ {GPS_DATA_W{prev_d30}},
              raw[GPS_PAR_W-1:0]}; // [RULE_07] [RULE_08] [RULE_17]
    end else if (gnss == GNSS_BDS && sig <= SIG_BDS_B2I_D2) begin
      word = {{PAD_W{1'b0}}, raw[BDS_WORD_W-1:0]}; // [RULE_09]
    end else if (gnss == GNSS_GAL && sig != SIG_GAL_E5A && alert &&
                 (idx == CNT_RST || idx == GAL_HALF2_IDX)) begin
      word[GAL_PTYPE_BIT] = 1'b1; // [RULE_13] [RULE_14]
    end
  end
endmodule

/* verilog/sfw_packer.sv */
`timescale 1ns/10ps
// Overview of operation
// [RULE_01] one record per complete decoded subframe
// [RULE_02] bits reported as received, checks kept
// [RULE_03] payload in 32-bit words, count given
// [RULE_04] record carries constellation id first
// [RULE_05] host ignores padding field contents
// [RULE_06] drop unless complete and parity passed
// [RULE_07] undo data inversion before output
// [RULE_08] gps l1 word: 2 pad, 24 data, 6 parity
// [RULE_09] beidou word: 2 pad, 22 data, 8 parity
// [RULE_10] glonass 85-bit string over three words
// [RULE_11] glonass fourth word: frame, superframe numbers
// [RULE_12] unidentified glonass satellite reported as 255
// [RULE_13] galileo e1b page pair, alert sets type
// [RULE_14] galileo e5b page pair in eight words
// [RULE_15] galileo e5a fnav page in eight words
// [RULE_16] sbas 250-bit block in data words
// [RULE_17] qzss layouts equal gps layouts
// [RULE_18] constellation codes 0,1,2,3,5,6,7
// [RULE_19] word count fixed per signal
// [RULE_20] header first, words held until accepted
module sfw_packer
  import sfw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic report_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [sfw_pkg::DATA_W-1:0] in_word,
  input wire logic in_last,
  input wire logic in_parity_ok,
  input wire logic [7:0] in_gnss_id,
  input wire logic [7:0] in_sig_id,
  input wire logic [7:0] in_sv_id,
  input wire logic in_sv_known,
  input wire logic in_alert,
  input wire logic [7:0] in_frame_num,
  input wire logic in_frame_known,
  input wire logic [7:0] in_superframe_num,
  input wire logic in_superframe_known,
  output logic out_valid,
  input wire logic out_ready,
  output logic [sfw_pkg::DATA_W-1:0] out_data,
  output logic out_header,
  output logic out_last,
  output logic drop_pulse
);
  import sfw_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // buffer must hold the longest record; count must not wrap
  if ((1 << ADDR_W) < MAX_WORDS) begin : g_bad_depth
    $error("sfw_packer: buffer shallower than longest record");
  end
  if ((1 << CNT_W) <= MAX_WORDS) begin : g_bad_count
    $error("sfw_packer: count field too narrow");
  end
  if (int'(WC_B1C) > MAX_WORDS) begin : g_bad_longest
    $error("sfw_packer: longest signal exceeds buffer");
  end
  // header and trailer layouts assume 32-bit words
  if (DATA_W != 32) begin : g_bad_width
    $error("sfw_packer: word width must be 32");
  end
  if (PAD_W + GPS_DATA_W + GPS_PAR_W != DATA_W) begin : g_bad_gps
    $error("sfw_packer: gps word fields do not fill a word");
  end
  if (PAD_W + BDS_WORD_W != DATA_W) begin : g_bad_bds
    $error("sfw_packer: beidou word fields do not fill a word");
  end
  if (GAL_PTYPE_BIT >= DATA_W) begin : g_bad_ptype
    $error("sfw_packer: page type bit outside the word");
  end
  if (int'(GAL_HALF2_IDX) >= int'(WC_GAL)) begin : g_bad_half
    $error("sfw_packer: second page starts past the record");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sfw_state_t st;
    logic [7:0] gnss;
    logic [7:0] sig;
    logic [7:0] sv;
    logic [7:0] frame;
    logic [7:0] sframe;
    logic alert;
    logic err;
    logic d30;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] idx;
    logic in_ready;
    logic out_valid;
    logic [DATA_W-1:0] out_data;
    logic out_header;
    logic out_last;
    logic drop;
  } sfw_regs_t;

  sfw_regs_t r_reg;
  sfw_regs_t r_next;

  sfw_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mif();

  logic [DATA_W-1:0] fmt_word;
  logic fmt_d30;
  logic [7:0] f_gnss;
  logic [7:0] f_sig;
  logic f_alert;
  logic [CNT_W-1:0] f_idx;
  logic f_d30;
  logic take;
  logic first;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // header word: ids, then the payload count
  function automatic logic [DATA_W-1:0] hdr_word(input sfw_regs_t r);
    return {r.gnss, r.sig, r.sv, 1'b0, r.cnt};
  endfunction

  // trailer: unknown numbers already forced to zero
  function automatic logic [DATA_W-1:0] trailer_word(input sfw_regs_t r);
    return {BYTE_RST, BYTE_RST, r.sframe, r.frame};
  endfunction

  // index of the final stored word in this record
  function automatic logic [CNT_W-1:0] last_idx(input sfw_regs_t r);
    return r.cnt - 7'h01;
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  sfw_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .clk(clk),
    .port(mif.mem)
  );

  sfw_fmt u_fmt (
    .gnss(f_gnss),
    .sig(f_sig),
    .idx(f_idx),
    .alert(f_alert),
    .prev_d30(f_d30),
    .raw(in_word),
    .word(fmt_word),
    .d30(fmt_d30)
  );

  // first word takes its ids straight from the inputs
  assign first = r_reg.st == ST_IDLE;
  assign take = in_valid && r_reg.in_ready;
  assign f_gnss = first ? in_gnss_id : r_reg.gnss;
  assign f_sig = first ? in_sig_id : r_reg.sig;
  assign f_alert = first ? in_alert : r_reg.alert;
  assign f_idx = first ? CNT_RST : r_reg.cnt;
  // inversion chain restarts at zero for each subframe
  assign f_d30 = first ? 1'b0 : r_reg.d30;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.drop = 1'b0;
    mif.we = 1'b0;
    mif.waddr = f_idx[ADDR_W-1:0];
    mif.wdata = fmt_word; // [RULE_02]
    unique case (r_reg.st)
      ST_IDLE: begin
        r_next.in_ready = 1'b1;
        if (take) begin
          r_next.gnss = in_gnss_id;
          r_next.sig = in_sig_id;
          r_next.alert = in_alert;
          r_next.sv = in_sv_id;
          if (in_gnss_id == GNSS_GLO && !in_sv_known) begin
            r_next.sv = SV_UNKNOWN; // [RULE_12]
          end
          r_next.frame = in_frame_known ? in_frame_num : BYTE_RST;
          r_next.sframe = in_superframe_known ?
                          in_superframe_num : BYTE_RST; // [RULE_11]
          mif.we = 1'b1;
          r_next.cnt = 7'h01;
          r_next.err = !in_parity_ok;
          r_next.d30 = fmt_d30;
          if (in_last) begin
            r_next.in_ready = 1'b0;
            r_next.st = ST_CHECK;
          end else begin
            r_next.st = ST_COLLECT;
          end
        end
      end
      ST_COLLECT: begin
        if (take) begin
          // overlong subframe is dropped, never wraps the buffer
          if (r_reg.cnt == CNT_W'(MAX_WORDS)) begin
            r_next.err = 1'b1; // [RULE_06]
          end else begin
            mif.we = 1'b1; // [RULE_10] [RULE_15] [RULE_16]
            r_next.cnt = r_reg.cnt + 7'h01;
          end
          if (!in_parity_ok) begin
            r_next.err = 1'b1; // [RULE_06]
          end
          r_next.d30 = fmt_d30;
          if (in_last) begin
            r_next.in_ready = 1'b0;
            r_next.st = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        if (!r_reg.err && report_en &&
            r_reg.cnt == sfw_word_count(r_reg.gnss, r_reg.sig)) begin
          // [RULE_01] [RULE_06] [RULE_19]
          r_next.st = ST_HDR;
          r_next.out_valid = 1'b1;
          r_next.out_header = 1'b1;
          r_next.out_data = hdr_word(r_reg); // [RULE_03] [RULE_04] [RULE_18]
          r_next.idx = CNT_RST;
        end else begin
          r_next.drop = 1'b1; // [RULE_06]
          r_next.st = ST_IDLE;
        end
      end
      ST_HDR: begin
        if (out_ready) begin
          r_next.out_valid = 1'b0;
          r_next.out_header = 1'b0;
          r_next.st = ST_LOAD; // [RULE_20]
        end
      end
      ST_LOAD: begin
        r_next.out_valid = 1'b1;
        r_next.out_data = mif.rdata;
        r_next.out_last = r_reg.idx == last_idx(r_reg) &&
                          r_reg.gnss != GNSS_GLO;
        r_next.st = ST_SEND;
      end
      ST_SEND: begin
        if (out_ready) begin
          r_next.out_valid = 1'b0;
          if (r_reg.out_last) begin
            r_next.out_last = 1'b0;
            r_next.st = ST_IDLE;
          end else if (r_reg.idx == last_idx(r_reg)) begin
            r_next.out_valid = 1'b1;
            r_next.out_last = 1'b1;
            r_next.out_data = trailer_word(r_reg); // [RULE_11]
            r_next.st = ST_TRAIL;
          end else begin
            r_next.idx = r_reg.idx + 7'h01; // [RULE_20]
            r_next.st = ST_LOAD;
          end
        end
      end
      ST_TRAIL: begin
        if (out_ready) begin
          r_next.out_valid = 1'b0;
          r_next.out_last = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
        r_next.in_ready = 1'b0;
        r_next.out_valid = 1'b0;
      end
    endcase
    // read address leads the state so data is ready in the load cycle
    mif.raddr = r_next.idx[ADDR_W-1:0];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '{st: ST_IDLE, gnss: BYTE_RST, sig: BYTE_RST,
                 sv: BYTE_RST, frame: BYTE_RST, sframe: BYTE_RST,
                 alert: 1'b0, err: 1'b0, d30: 1'b0, cnt: CNT_RST,
                 idx: CNT_RST, in_ready: 1'b0, out_valid: 1'b0,
                 out_data: DATA_RST, out_header: 1'b0,
                 out_last: 1'b0, drop: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready = r_reg.in_ready;
  assign out_valid = r_reg.out_valid;
  assign out_data = r_reg.out_data;
  assign out_header = r_reg.out_header;
  assign out_last = r_reg.out_last;
  assign drop_pulse = r_reg.drop;
endmodule

/* verification/sfw_packer_chk.sv */
`timescale 1ns/10ps
module sfw_packer_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic report_en,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_last,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [31:0] out_data,
  input wire logic out_header,
  input wire logic out_last,
  input wire logic drop_pulse
);
  // ------
  // record timing
  // ------
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_last_in;
    in_valid && in_ready && in_last;
  endsequence
  sequence s_answer;
    !in_ready ##1 (out_valid && out_header || drop_pulse);
  endsequence
  chk_check_gap: assert property (s_last_in |=> s_answer)
    else $error("no header or drop two cycles after last word");
  chk_enable_off: assert property (
    in_valid && in_ready && in_last && !report_en ##1 !report_en
    |=> drop_pulse)
    else $error("disabled report not dropped");
  chk_drop_quiet: assert property (
    drop_pulse |-> !out_valid ##1 !drop_pulse)
    else $error("drop pulse with output or too long");
  chk_hold_word: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word not held");
  chk_input_busy: assert property (out_valid |-> !in_ready)
    else $error("input ready while sending");
  chk_load_gap: assert property (
    out_valid && out_header && out_ready
    |=> !out_valid ##1 out_valid && !out_header)
    else $error("payload not two cycles after header");
  chk_last_end: assert property (
    out_valid && out_last && out_ready
    |=> !out_valid && !out_last ##1 in_ready)
    else $error("record end not followed by ready");
  chk_gnss_code: assert property (
    out_valid && out_header |-> out_data[31:24] inside {8'h00, 8'h01,
    8'h02, 8'h03, 8'h05, 8'h06, 8'h07})
    else $error("bad constellation code");
  chk_gal_count: assert property (
    out_valid && out_header && out_data[31:24] == 8'h02
    |-> out_data[7:0] == 8'h08)
    else $error("galileo count not eight");
  chk_glo_count: assert property (
    out_valid && out_header && out_data[31:24] == 8'h06
    |-> out_data[7:0] == 8'h03)
    else $error("glonass count not three");
endmodule
bind sfw_packer sfw_packer_chk i_sfw_packer_chk (.clk(clk), .rst(rst),
  .report_en(report_en), .in_valid(in_valid), .in_ready(in_ready),
  .in_last(in_last), .out_valid(out_valid), .out_ready(out_ready),
  .out_data(out_data), .out_header(out_header), .out_last(out_last),
  .drop_pulse(drop_pulse));

/* verification/sfw_host_model.sv */
`timescale 1ns/10ps
module sfw_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [31:0] out_data,
  input wire logic out_header,
  output logic take,
  output logic [31:0] word
);
  // ------
  // host side
  // ------
  logic [1:0] cnt_reg;
  logic [7:0] gnss_reg;
  logic padded;
  always_ff @(posedge clk) begin
    if (rst)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_reg + 2'h1;
    if (take && out_header)
      gnss_reg <= out_data[31:24];
  end
  // slow mode is ready one cycle in four so holds get exercised
  assign out_ready = !rst && (!slow || cnt_reg == 2'h3);
  assign take = out_valid && out_ready;
  assign padded = gnss_reg == 8'h00 || gnss_reg == 8'h03 ||
    gnss_reg == 8'h05;
  // pad contents never trusted
  assign word = (!out_header && padded) ?
    {2'h0, out_data[29:0]} : out_data;
endmodule

/* verification/sfw_packer_test.sv */
`timescale 1ns/10ps
module sfw_packer_test;
  import sfw_pkg::*;
  typedef struct packed {
    logic [7:0] g;
    logic [7:0] s;
    logic [6:0] n;
    logic a;
    logic w;
  } sfw_row_t;
  logic clk, rst, report_en, in_valid, in_last, in_parity_ok, slow;
  logic in_sv_known, in_alert, in_frame_known, in_superframe_known;
  logic [31:0] in_word, out_data, word;
  logic [7:0] in_gnss_id, in_sig_id, in_sv_id, in_frame_num;
  logic [7:0] in_superframe_num;
  logic in_ready, out_valid, out_ready, out_header, out_last;
  logic drop_pulse, take;
  logic [31:0] exp_q[$];
  int errors, cmp_count, ends, drops, cyc;
  logic hdr_next = 1'b1;
  // ------
  // rows: gnss, signal, words, alert, slow host
  // ------
  sfw_row_t rows[13] = '{'{8'h0, 8'h0, 7'hA, 1'b0, 1'b1},
    '{8'h0, 8'h3, 7'hA, 1'b0, 1'b0}, '{8'h1, 8'h0, 7'h9, 1'b0, 1'b0},
    '{8'h2, 8'h1, 7'h8, 1'b1, 1'b0}, '{8'h2, 8'h5, 7'h8, 1'b1, 1'b1},
    '{8'h2, 8'h3, 7'h8, 1'b1, 1'b0}, '{8'h3, 8'h0, 7'hA, 1'b0, 1'b0},
    '{8'h3, 8'h5, 7'h39, 1'b0, 1'b0}, '{8'h3, 8'h7, 7'h9, 1'b0, 1'b1},
    '{8'h5, 8'h0, 7'hA, 1'b0, 1'b0}, '{8'h5, 8'h8, 7'hA, 1'b0, 1'b0},
    '{8'h6, 8'h0, 7'h3, 1'b0, 1'b0}, '{8'h7, 8'h0, 7'hA, 1'b0, 1'b0}};
  sfw_packer i_sfw_packer (.clk(clk), .rst(rst), .report_en(report_en),
    .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
    .in_last(in_last), .in_parity_ok(in_parity_ok),
    .in_gnss_id(in_gnss_id), .in_sig_id(in_sig_id), .in_sv_id(in_sv_id),
    .in_sv_known(in_sv_known), .in_alert(in_alert),
    .in_frame_num(in_frame_num), .in_frame_known(in_frame_known),
    .in_superframe_num(in_superframe_num),
    .in_superframe_known(in_superframe_known), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_header(out_header),
    .out_last(out_last), .drop_pulse(drop_pulse));
  sfw_host_model i_sfw_host_model (.clk(clk), .rst(rst), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_header(out_header), .take(take), .word(word));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------
  // one subframe in, expected record queued
  // ------
  task automatic run(input sfw_row_t r, input logic good, input logic pb);
    logic [31:0] raw, e;
    logic prev;
    int i, e0, d0;
    prev = 1'b0;
    e0 = ends;
    d0 = drops;
    slow = r.w;
    if (good)
      exp_q.push_back({r.g, r.s, (r.g == GNSS_GLO && !in_sv_known) ?
        SV_UNKNOWN : in_sv_id, 1'b0, r.g == GNSS_GLO ? WC_GLO : r.n});
    for (i = 0; i < r.n; i++) begin
      raw = 32'h15A5A5C0 + 32'h00010101 * i;
      e = raw;
      if ((r.g == GNSS_GPS || r.g == GNSS_QZSS) && r.s == SIG_L1CA)
        e = {2'h0, raw[29:6] ^ {24{prev}}, raw[5:0]};
      if (r.a && r.g == GNSS_GAL && r.s != SIG_GAL_E5A && i % 4 == 0)
        e[30] = 1'b1;
      prev = raw[0];
      if (good)
        exp_q.push_back(e);
      @(negedge clk);
      {in_valid, in_word, in_last, in_parity_ok} =
        {1'b1, raw, i == r.n - 1, !(pb && i == 1)};
      {in_gnss_id, in_sig_id, in_alert} = {r.g, r.s, r.a};
      while (in_ready !== 1'b1)
        @(negedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
    in_last = 1'b0;
    if (good && r.g == GNSS_GLO)
      exp_q.push_back({16'h0, in_superframe_known ? in_superframe_num :
        8'h0, in_frame_known ? in_frame_num : 8'h0});
    for (i = 0; i < 600 && ends == e0 && drops == d0; i++)
      @(negedge clk);
    check({31'h0, drops != d0}, {31'h0, !good});
    check({31'h0, ends != e0}, {31'h0, good});
    check(32'(exp_q.size()), 32'h0);
    repeat (3) @(negedge clk);
  endtask
  // sampled half a cycle ahead of the edge that takes the word
  always @(negedge clk) begin
    if (take) begin
      check(word, exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
      check({31'h0, out_header}, {31'h0, hdr_next});
      hdr_next = out_last;
      if (out_last)
        ends++;
    end
    if (drop_pulse)
      drops++;
    cyc++;
    // ceiling well above the whole test run
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, report_en, in_valid, in_last, in_parity_ok, slow} = 6'h33;
    {in_sv_known, in_alert, in_frame_known, in_superframe_known} = 4'hB;
    {in_word, in_gnss_id, in_sig_id} = 48'h0;
    {in_sv_id, in_frame_num, in_superframe_num} = 24'h171234;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check({31'h0, out_valid}, 32'h0);
    foreach (rows[k])
      run(rows[k], 1'b1, 1'b0);
    run(rows[0], 1'b0, 1'b1);
    run('{8'h3, 8'h5, 7'h41, 1'b0, 1'b0}, 1'b0, 1'b0);
    run('{8'h4, 8'h0, 7'hA, 1'b0, 1'b0}, 1'b0, 1'b0);
    report_en = 1'b0;
    run(rows[3], 1'b0, 1'b0);
    report_en = 1'b1;
    run('{8'h2, 8'h1, 7'h7, 1'b0, 1'b0}, 1'b0, 1'b0);
    {in_sv_known, in_frame_known} = 2'h0;
    run(rows[11], 1'b1, 1'b0);
    // reset in mid-subframe: the partial words must vanish
    {in_valid, in_word, in_last, in_parity_ok} = {1'b1, 32'h0, 2'h1};
    {in_gnss_id, in_sig_id} = 16'h0;
    repeat (3) @(negedge clk);
    {rst, in_valid} = 2'h2;
    @(negedge clk);
    rst = 1'b0;
    check({28'h0, in_ready, out_valid, out_header, out_last}, 32'h0);
    check(out_data, 32'h0);
    check({31'h0, drop_pulse}, 32'h0);
    @(negedge clk);
    check({31'h0, in_ready}, 32'h1);
    run(rows[0], 1'b1, 1'b0);
    print_verdict();
  end
endmodule
